/* File: sonet_oh_pkg.sv */
// Constants shared by the section and line overhead register block.
// Assumes an 8-bit register port, a byte-wide transmit stream and receive event counts.
package sonet_oh_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_LOAD_METERS    = 8'h00;
    localparam logic [7:0] ADDR_SEC_CNT_LOW    = 8'h12;
    localparam logic [7:0] ADDR_SEC_CNT_HIGH   = 8'h13;
    localparam logic [7:0] ADDR_TX_SEC_CTRL    = 8'h14;
    localparam logic [7:0] ADDR_TX_SEC_DIAG    = 8'h15;
    localparam logic [7:0] ADDR_RX_LINE_CTRL   = 8'h18;
    localparam logic [7:0] ADDR_RX_LINE_INT    = 8'h19;
    localparam logic [7:0] ADDR_LINE_CNT_LOW   = 8'h1a;
    localparam logic [7:0] ADDR_LINE_CNT_MID   = 8'h1b;
    localparam logic [7:0] ADDR_LINE_CNT_HIGH  = 8'h1c;
    localparam logic [7:0] ADDR_LINE_FEBE_LAST = 8'h1f;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TXC_LINE_ALARM_INSERT  = 0;
    localparam int TXC_SCRAMBLER_DISABLE  = 6;
    localparam int TXD_FRAMING_ERR_INSERT = 0;
    localparam int TXD_SECTION_PAR_CORRUPT = 1;
    localparam int TXD_ALL_ZERO_INSERT    = 2;
    localparam int RLC_BLOCK_COUNT_MODE   = 4;
    localparam int FLG_RDI                = 0;
    localparam int FLG_ALARM              = 1;
    localparam int FLG_PARITY             = 2;
    localparam int FLG_FAR_ERROR          = 3;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int SEC_CNT_W  = 16;
    localparam int LINE_CNT_W = 20;
    localparam logic [6:0] TX_CTRL_RESET   = 7'h00;
    localparam logic [2:0] TX_DIAG_RESET   = 3'h0;
    localparam logic [4:0] RX_CTRL_RESET   = 5'h00;
    localparam logic [3:0] IRQ_EN_RESET    = 4'h0;

    // ****************************************************************
    // Stream values
    // ****************************************************************
    localparam logic [7:0] A1_GOOD        = 8'hf6;
    localparam logic [7:0] A1_ERRORED     = 8'h76;
    localparam logic [7:0] ALARM_BYTE     = 8'hff;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam logic [6:0] SCRAMBLER_SEED = 7'h7f;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ          = 125;
    localparam int POLL_TIME_US     = 7;
    localparam int POLL_MAX_CYCLES  = POLL_TIME_US * CLK_MHZ;
    localparam int POLL_USED_CYCLES = 1;

endpackage

/* File: sonet_section_line_overhead_regs.sv */
// Section and line overhead control and monitoring with its register port.
// Assumes receive event inputs come from logic on i_core_clk; only the
// external line alarm request is asynchronous and is synchronised here.
//
// Behaviour
// [RL1] Sixteen-bit section parity error count since last poll, low and high byte.
// [RL2] Write to either section count address snapshots accumulator and restarts it.
// [RL3] Errors coinciding with a poll land in the old or new interval.
// [RL4] Any write to address zero snapshots every error counter at once.
// [RL5] Line alarm forces non-section-overhead bits to one, switched at frame start.
// [RL6] Line alarm request is software bit OR external request pin.
// [RL7] Scrambler disable bit one sends unscrambled, zero scrambles.
// [RL8] Framing error insert sends A1 as 0x76 instead of 0xF6.
// [RL9] Section parity corrupt sends inverted computed B1 byte.
// [RL10] All-zero insert forces the whole transmit stream to 0x00.
// [RL11] Read-only status bits show line RDI and line alarm states.
// [RL12] Block mode counts once per errored frame, else once per errored bit.
// [RL13] RDI and alarm change flags set on each change, cleared on read.
// [RL14] Parity and far error flags set on B2 error or Z2 indication, read clears.
// [RL15] Four enables gate the change and error flags onto the interrupt output.
// [RL16] Twenty-bit line parity error count over three byte registers, top nibble zero.
// [RL17] Write to any line count address snapshots line accumulator and restarts it.
// [RL18] Snapshot registers hold their value between polls.
// [RL19] Software waits for the transfer before reading and writes reserved bits zero.
//
// Added by the designer: the strobed register port.

`timescale 1ns/10ps

module sonet_section_line_overhead_regs (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Interrupt and meter load
    output logic            o_irq,
    output logic            o_load_meters,
    // External line alarm request pin
    input  wire logic       i_ext_line_alarm_req,
    // Transmit stream in
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_valid,
    input  wire logic       i_tx_frame_start,
    input  wire logic       i_tx_soh,
    input  wire logic       i_tx_a1,
    input  wire logic       i_tx_b1,
    input  wire logic       i_tx_no_scr,
    // Transmit stream out
    output logic      [7:0] o_tx_byte,
    output logic            o_tx_valid,
    // Receive section and line events
    input  wire logic [3:0] i_rx_sec_err_bits,
    input  wire logic [4:0] i_rx_line_err_bits,
    input  wire logic       i_rx_line_frame_end,
    input  wire logic       i_rx_line_febe,
    input  wire logic       i_rx_line_rdi,
    input  wire logic       i_rx_line_alarm
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                                ext_sync1;
        logic                                ext_sync2;
        logic                                alarm_active;
        logic [6:0]                          tx_ctrl;
        logic [2:0]                          tx_diag;
        logic [6:0]                          scr;
        logic [7:0]                          bip;
        logic [7:0]                          bip_run;
        logic [7:0]                          tx_byte;
        logic                                tx_valid;
        logic [4:0]                          rx_ctrl;
        logic                                line_rdi_state;
        logic                                line_alarm_state;
        logic [3:0]                          irq_en;
        logic [3:0]                          flags;
        logic [sonet_oh_pkg::SEC_CNT_W-1:0]  sec_acc;
        logic [sonet_oh_pkg::SEC_CNT_W-1:0]  section_err_count;
        logic [sonet_oh_pkg::LINE_CNT_W-1:0] line_acc;
        logic [sonet_oh_pkg::LINE_CNT_W-1:0] line_err_count;
        logic                                frame_err;
        logic [7:0]                          rdata;
        logic                                irq;
        logic                                load_meters;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ****************************************************************
    // Byte-wide frame synchronous scrambler, one stage per bit
    // ****************************************************************
    logic [6:0] scr_chain [0:8];
    logic [7:0] scr_key;

    // Seeding at frame start keeps the far end's descrambler in step.
    assign scr_chain[0] = i_tx_frame_start ? sonet_oh_pkg::SCRAMBLER_SEED : st_q.scr;

    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_scr
            assign scr_key[7-k]    = scr_chain[k][6];
            assign scr_chain[k+1]  = {scr_chain[k][5:0], scr_chain[k][6] ^ scr_chain[k][5]};
        end
    endgenerate

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    logic                                 line_alarm_insert;
    logic                                 scrambler_disable;
    logic                                 framing_error_insert;
    logic                                 section_parity_corrupt;
    logic                                 all_zero_insert;
    logic                                 block_count_mode;
    logic                                 alarm_req;
    logic                                 do_scramble;
    logic [7:0]                           pre_byte;
    logic [7:0]                           scr_byte;
    logic                                 wr_load;
    logic                                 sec_poll;
    logic                                 line_poll;
    logic [sonet_oh_pkg::SEC_CNT_W:0]     sec_sum;
    logic [sonet_oh_pkg::LINE_CNT_W:0]    line_sum;
    logic [sonet_oh_pkg::SEC_CNT_W-1:0]   sec_inc;
    logic [sonet_oh_pkg::LINE_CNT_W-1:0]  line_inc;
    logic [sonet_oh_pkg::SEC_CNT_W-1:0]   sec_next;
    logic [sonet_oh_pkg::LINE_CNT_W-1:0]  line_next;
    logic [3:0]                           flag_set;
    logic [3:0]                           flag_clr;
    logic                                 line_err_now;

    always_comb begin
        st_d = st_q;

        line_alarm_insert      = st_q.tx_ctrl[sonet_oh_pkg::TXC_LINE_ALARM_INSERT];
        scrambler_disable      = st_q.tx_ctrl[sonet_oh_pkg::TXC_SCRAMBLER_DISABLE];
        framing_error_insert   = st_q.tx_diag[sonet_oh_pkg::TXD_FRAMING_ERR_INSERT];
        section_parity_corrupt = st_q.tx_diag[sonet_oh_pkg::TXD_SECTION_PAR_CORRUPT];
        all_zero_insert        = st_q.tx_diag[sonet_oh_pkg::TXD_ALL_ZERO_INSERT];
        block_count_mode       = st_q.rx_ctrl[sonet_oh_pkg::RLC_BLOCK_COUNT_MODE];

        // External pin passes two flip-flops before use.
        st_d.ext_sync1 = i_ext_line_alarm_req;
        st_d.ext_sync2 = st_q.ext_sync1;

        // ************************************************************
        // Transmit section path
        // ************************************************************
        alarm_req = line_alarm_insert | st_q.ext_sync2; // RL6
        pre_byte  = i_tx_byte;
        scr_byte  = i_tx_byte;
        do_scramble = 1'b0;

        st_d.tx_valid = i_tx_valid;
        if (i_tx_valid) begin
            if (i_tx_frame_start) begin
                // Switching only here keeps partial alarm frames off the line.
                st_d.alarm_active = alarm_req; // RL5
                st_d.bip          = st_q.bip_run;
            end

            if (st_d.alarm_active && !i_tx_soh) begin
                pre_byte = sonet_oh_pkg::ALARM_BYTE; // RL5
            end

            if (i_tx_a1) begin
                pre_byte = framing_error_insert ? sonet_oh_pkg::A1_ERRORED
                                                : sonet_oh_pkg::A1_GOOD; // RL8
            end

            if (i_tx_b1) begin
                pre_byte = section_parity_corrupt ? ~st_d.bip : st_d.bip; // RL9
            end

            do_scramble = !scrambler_disable && !i_tx_no_scr; // RL7
            scr_byte    = do_scramble ? (pre_byte ^ scr_key) : pre_byte; // RL7
            if (do_scramble) begin
                st_d.scr = scr_chain[8];
            end else if (i_tx_frame_start) begin
                st_d.scr = sonet_oh_pkg::SCRAMBLER_SEED;
            end

            // Parity covers the scrambled frame and lands in the next one.
            st_d.bip_run = i_tx_frame_start ? scr_byte : (st_q.bip_run ^ scr_byte);
            st_d.tx_byte = all_zero_insert ? sonet_oh_pkg::ZERO_BYTE : scr_byte; // RL10
        end else begin
            st_d.tx_byte = all_zero_insert ? sonet_oh_pkg::ZERO_BYTE : st_q.tx_byte; // RL10
        end

        // ************************************************************
        // Register writes and poll triggers
        // ************************************************************
        wr_load   = i_wr && (i_addr == sonet_oh_pkg::ADDR_LOAD_METERS);
        sec_poll  = wr_load
                  || (i_wr && (i_addr == sonet_oh_pkg::ADDR_SEC_CNT_LOW
                  ||           i_addr == sonet_oh_pkg::ADDR_SEC_CNT_HIGH)); // RL2 RL4

        // The far-error counter is not kept; its addresses only trigger the line poll.
        line_poll = wr_load
                  || (i_wr && (i_addr >= sonet_oh_pkg::ADDR_LINE_CNT_LOW)
                           && (i_addr <= sonet_oh_pkg::ADDR_LINE_FEBE_LAST)); // RL17 RL4
        st_d.load_meters = wr_load; // RL4


        if (i_wr) begin
            unique case (i_addr)
                sonet_oh_pkg::ADDR_TX_SEC_CTRL:  st_d.tx_ctrl = i_wdata[6:0];
                sonet_oh_pkg::ADDR_TX_SEC_DIAG:  st_d.tx_diag = i_wdata[2:0];
                sonet_oh_pkg::ADDR_RX_LINE_CTRL: st_d.rx_ctrl = i_wdata[7:3];
                sonet_oh_pkg::ADDR_RX_LINE_INT:  st_d.irq_en  = i_wdata[7:4];
                default: begin
                end
            endcase
        end

        // ************************************************************
        // Section parity error accumulation
        // ************************************************************
        sec_inc = sonet_oh_pkg::SEC_CNT_W'(i_rx_sec_err_bits);
        sec_sum = {1'b0, st_q.sec_acc} + {1'b0, sec_inc};
        sec_next = sec_sum[sonet_oh_pkg::SEC_CNT_W] ? '1
                                                     : sec_sum[sonet_oh_pkg::SEC_CNT_W-1:0];

        if (sec_poll) begin
            // This cycle's errors open the new interval, so none is lost.
            st_d.section_err_count = st_q.sec_acc; // RL1 RL2
            st_d.sec_acc           = sec_inc; // RL3
        end else begin
            st_d.sec_acc = sec_next; // RL18
        end

        // ************************************************************
        // Line parity error accumulation
        // ************************************************************
        line_err_now = (i_rx_line_err_bits != 5'h00);
        line_inc     = '0;

        if (block_count_mode) begin
            if (i_rx_line_frame_end) begin
                line_inc       = count_bit(st_q.frame_err | line_err_now); // RL12
                st_d.frame_err = 1'b0;
            end else if (line_err_now) begin
                st_d.frame_err = 1'b1;
            end
        end else begin
            line_inc       = sonet_oh_pkg::LINE_CNT_W'(i_rx_line_err_bits); // RL12
            st_d.frame_err = 1'b0;
        end

        line_sum  = {1'b0, st_q.line_acc} + {1'b0, line_inc};
        line_next = line_sum[sonet_oh_pkg::LINE_CNT_W] ? '1
                                                        : line_sum[sonet_oh_pkg::LINE_CNT_W-1:0];

        if (line_poll) begin
            st_d.line_err_count = st_q.line_acc; // RL16 RL17
            st_d.line_acc       = line_inc;
        end else begin
            st_d.line_acc = line_next; // RL18
        end

        // ************************************************************
        // Line status and event flags
        // ************************************************************
        st_d.line_rdi_state   = i_rx_line_rdi; // RL11
        st_d.line_alarm_state = i_rx_line_alarm; // RL11


        flag_set = '0;
        flag_set[sonet_oh_pkg::FLG_RDI]       = i_rx_line_rdi != st_q.line_rdi_state; // RL13
        flag_set[sonet_oh_pkg::FLG_ALARM]     = i_rx_line_alarm != st_q.line_alarm_state; // RL13
        flag_set[sonet_oh_pkg::FLG_PARITY]    = line_err_now; // RL14
        flag_set[sonet_oh_pkg::FLG_FAR_ERROR] = i_rx_line_febe; // RL14

        flag_clr = {4{i_rd && (i_addr == sonet_oh_pkg::ADDR_RX_LINE_INT)}};
        // A new event in the clearing read cycle survives to the next read.
        st_d.flags = (st_q.flags & ~flag_clr) | flag_set; // RL13 RL14

        st_d.irq   = |(st_d.flags & st_d.irq_en); // RL15

        // ************************************************************
        // Register reads
        // ************************************************************
        st_d.rdata = 8'h00;

        if (i_rd) begin
            unique case (i_addr)
                sonet_oh_pkg::ADDR_SEC_CNT_LOW:  st_d.rdata = st_q.section_err_count[7:0];
                sonet_oh_pkg::ADDR_SEC_CNT_HIGH: st_d.rdata = st_q.section_err_count[15:8];
                sonet_oh_pkg::ADDR_TX_SEC_CTRL:  st_d.rdata = {1'b0, st_q.tx_ctrl};
                sonet_oh_pkg::ADDR_TX_SEC_DIAG:  st_d.rdata = {5'h00, st_q.tx_diag};
                sonet_oh_pkg::ADDR_RX_LINE_CTRL: st_d.rdata = {st_q.rx_ctrl, 1'b0,
                                                               st_q.line_alarm_state,
                                                               st_q.line_rdi_state}; // RL11
                sonet_oh_pkg::ADDR_RX_LINE_INT:  st_d.rdata = {st_q.irq_en, st_q.flags};
                sonet_oh_pkg::ADDR_LINE_CNT_LOW: st_d.rdata = st_q.line_err_count[7:0];
                sonet_oh_pkg::ADDR_LINE_CNT_MID: st_d.rdata = st_q.line_err_count[15:8];
                sonet_oh_pkg::ADDR_LINE_CNT_HIGH: st_d.rdata = {4'h0,
                                                                st_q.line_err_count[19:16]}; // RL16
                default: begin
                end
            endcase
        end
    end

    // Widens a single count bit to the line counter width.
    function automatic logic [sonet_oh_pkg::LINE_CNT_W-1:0] count_bit(input logic b);
        count_bit = {{(sonet_oh_pkg::LINE_CNT_W-1){1'b0}}, b};
    endfunction

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_q                   <= '0;
            st_q.tx_ctrl           <= sonet_oh_pkg::TX_CTRL_RESET;
            st_q.tx_diag           <= sonet_oh_pkg::TX_DIAG_RESET;
            st_q.rx_ctrl           <= sonet_oh_pkg::RX_CTRL_RESET;
            st_q.irq_en            <= sonet_oh_pkg::IRQ_EN_RESET;
            st_q.scr               <= sonet_oh_pkg::SCRAMBLER_SEED;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_rdata       = st_q.rdata;
    assign o_irq         = st_q.irq;
    assign o_load_meters = st_q.load_meters;
    assign o_tx_byte     = st_q.tx_byte;
    assign o_tx_valid    = st_q.tx_valid;

endmodule

/* File: sonet_line_far_end.sv */
// Far-end line model: receive error counts, frame marks and alarms.
// Assumes its tasks are called from the bench.
`timescale 1ns/10ps
module sonet_line_far_end (
    input  wire logic       i_core_clk,
    output logic      [3:0] o_sec_err,
    output logic      [4:0] o_line_err,
    output logic            o_frame_end,
    output logic            o_febe,
    output logic            o_rdi,
    output logic            o_alarm
);
    initial {o_sec_err, o_line_err, o_frame_end, o_febe, o_rdi, o_alarm} = '0;
    // Counts stay far below saturation.
    task automatic errs(input logic [3:0] s, input logic [4:0] l, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            o_sec_err  <= s;
            o_line_err <= l;
        end
        @(posedge i_core_clk);
        o_sec_err  <= 4'h0;
        o_line_err <= 5'h00;
    endtask
    task automatic mark(input logic f, input logic b);
        @(posedge i_core_clk);
        o_frame_end <= f;
        o_febe      <= b;
        @(posedge i_core_clk);
        o_frame_end <= 1'b0;
        o_febe      <= 1'b0;
    endtask
    task automatic state(input logic r, input logic a);
        @(posedge i_core_clk);
        o_rdi   <= r;
        o_alarm <= a;
    endtask
endmodule

/* File: sonet_oh_sva.sv */
// Port-level checker for the overhead register block.
// Assumes it is bound into the block.
`timescale 1ns/10ps
module sonet_oh_sva (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq,
    input wire logic       o_load_meters,
    input wire logic [7:0] o_tx_byte,
    input wire logic       i_tx_valid,
    input wire logic       i_tx_a1,
    input wire logic       i_rx_line_rdi
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic fp_q;
    logic zero_q;
    // Mirror of the framing error and all-zero diagnostic bits, so stream checks know what is forced.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fp_q   <= 1'b0;
            zero_q <= 1'b0;
        end else if (i_wr && i_addr == sonet_oh_pkg::ADDR_TX_SEC_DIAG) begin
            fp_q   <= i_wdata[0];
            zero_q <= i_wdata[2];
        end
    end
    sequence s_load;
        i_wr && i_addr == sonet_oh_pkg::ADDR_LOAD_METERS;
    endsequence
    sequence s_a1;
        i_tx_valid && i_tx_a1 && !zero_q;
    endsequence
    a_load_pulse: assert property (s_load |=> o_load_meters)
        else $error("no load pulse");
    a_load_cause: assert property (o_load_meters |-> $past(i_wr && i_addr == 8'h00))
        else $error("stray load pulse");
    a_zero_fill: assert property (zero_q |=> o_tx_byte == 8'h00)
        else $error("not all zero");
    a_a1_error: assert property (s_a1 ##0 fp_q |=> o_tx_byte == 8'h76)
        else $error("bad errored A1");
    a_a1_good: assert property (s_a1 ##0 !fp_q |=> o_tx_byte == 8'hf6)
        else $error("bad A1");
    a_irq_gate: assert property ((i_wr && i_addr == 8'h19 && i_wdata[7:4] == 4'h0)
        |-> ##2 !o_irq)
        else $error("irq while disabled");
    a_rdi_state: assert property ((i_rd && i_addr == 8'h18)
        |=> o_rdata[0] == $past(i_rx_line_rdi, 2))
        else $error("bad rdi state");
    a_cnt_top: assert property ((i_rd && i_addr == 8'h1c) |=> o_rdata[7:4] == 4'h0)
        else $error("top nibble set");
endmodule
bind sonet_section_line_overhead_regs sonet_oh_sva u_sva (.*);

/* File: test_sonet_section_line_overhead_regs.sv */
// Self-checking bench for the overhead register block.
// Assumes the far-end model and checker are compiled with it.
`timescale 1ns/10ps
module test_sonet_section_line_overhead_regs;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0, tv = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, txb = 8'h00;
    logic [4:0]  tf = 5'h00;
    logic [7:0]  rdata, txo, v, q [$];
    logic        irq, lm, lmv, txv, fe, fb, rdi, al;
    logic [3:0]  se;
    logic [4:0]  le;
    logic [23:0] c;
    logic [15:0] a;
    int          failures = 0;
    int          check_count = 0;
    sonet_section_line_overhead_regs dut (
        .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_load_meters(lm),
        .i_ext_line_alarm_req(pin), .i_tx_byte(txb), .i_tx_valid(tv),
        .i_tx_frame_start(tf[4]), .i_tx_soh(tf[3]), .i_tx_a1(tf[2]), .i_tx_b1(tf[1]),
        .i_tx_no_scr(tf[0]), .o_tx_byte(txo), .o_tx_valid(txv),
        .i_rx_sec_err_bits(se), .i_rx_line_err_bits(le), .i_rx_line_frame_end(fe),
        .i_rx_line_febe(fb), .i_rx_line_rdi(rdi), .i_rx_line_alarm(al));
    sonet_line_far_end far (.i_core_clk(clk), .o_sec_err(se), .o_line_err(le),
        .o_frame_end(fe), .o_febe(fb), .o_rdi(rdi), .o_alarm(al));
    always #4 clk = ~clk;
    always @(posedge clk) if (txv === 1'b1) q.push_back(txo);
    task end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= ad;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1 lmv = lm;
    endtask
    task automatic rget(input logic [7:0] ad);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        rget(ad);
        chk(v, e);
    endtask
    task rd3(input logic [7:0] b);
        for (int i = 0; i < 3; i++) begin
            rget(b + i[7:0]);
            c[8*i +: 8] = v;
        end
    endtask
    task automatic frame(input logic b1);
        logic [7:0] by [4];
        logic [4:0] fl [4];
        by = '{8'hf6, 8'h11, 8'h3c, 8'h5a};
        fl = '{5'h1d, 5'h09, 5'h00, b1 ? 5'h0a : 5'h00};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tv  <= 1'b1;
            txb <= by[i];
            tf  <= fl[i];
        end
    endtask
    task idle();
        @(posedge clk);
        tv <= 1'b0;
        tf <= 5'h00;
        repeat (3) @(posedge clk);
    endtask
    task t_regs();
        logic [7:0] ra [4];
        logic [7:0] re [4];
        ra = '{8'h14, 8'h15, 8'h18, 8'h05};
        re = '{8'h7f, 8'h07, 8'hf8, 8'h00};
        rchk(8'h19, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rchk(ra[i], 8'h00);
            wrr(ra[i], 8'hff);
            rchk(ra[i], re[i]);
            wrr(ra[i], 8'h00);
        end
    endtask
    task t_sec();
        wrr(8'h13, 8'h00);
        far.errs(4'h8, 5'h00, 300);
        wrr(sonet_oh_pkg::ADDR_SEC_CNT_LOW, 8'h00);
        repeat (sonet_oh_pkg::POLL_USED_CYCLES) @(posedge clk);
        rd3(8'h12);
        chk(c[15:0], 16'd2400);
        // Errors keep arriving across the poll; none may be lost.
        fork
            far.errs(4'h1, 5'h00, 200);
            begin
                repeat (100) @(posedge clk);
                wrr(8'h13, 8'h00);
            end
        join
        rd3(8'h12);
        a = c[15:0];
        wrr(sonet_oh_pkg::ADDR_LOAD_METERS, 8'h00);
        chk(lmv, 1'b1);
        rd3(8'h12);
        chk(a + c[15:0], 16'd200);
        far.errs(4'h8, 5'h00, 10);
        rchk(8'h12, c[7:0]);
    endtask
    task t_line();
        far.errs(4'h0, 5'd24, 10);
        wrr(sonet_oh_pkg::ADDR_LINE_FEBE_LAST, 8'h00);
        rd3(8'h1a);
        chk(c, 24'd240);
        wrr(8'h18, 8'h80);
        far.errs(4'h0, 5'd3, 5);
        far.mark(1'b1, 1'b0);
        far.mark(1'b1, 1'b0);
        far.errs(4'h0, 5'd24, 1);
        far.mark(1'b1, 1'b1);
        wrr(8'h1a, 8'h00);
        rd3(8'h1a);
        chk(c, 24'd2);
        wrr(8'h18, 8'h00);
        rchk(8'h19, 8'h0c);
        rchk(8'h19, 8'h00);
        wrr(8'h19, 8'h10);
        far.state(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b1);
        rchk(8'h18, 8'h01);
        rchk(8'h19, 8'h11);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0);
        far.state(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b0);
        rchk(8'h18, 8'h03);
        rchk(8'h19, 8'h12);
        far.state(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b1);
        wrr(8'h19, 8'h00);
    endtask
    task t_tx();
        wrr(8'h14, 8'h40);
        q.delete();
        frame(1'b0);
        frame(1'b1);
        idle();
        chk(q[7], 8'h81);
        wrr(8'h15, 8'h03);
        q.delete();
        frame(1'b0);
        frame(1'b1);
        idle();
        chk(q[0], 8'h76);
        chk(q[7], 8'hfe);
        wrr(8'h15, 8'h04);
        frame(1'b0);
        wrr(8'h15, 8'h00);
        idle();
        q.delete();
        // Alarm changes mid-frame must wait for the next frame start.
        fork
            frame(1'b0);
            wrr(8'h14, 8'h41);
        join
        fork
            frame(1'b0);
            wrr(8'h14, 8'h40);
        join
        pin <= 1'b1;
        frame(1'b0);
        frame(1'b0);
        pin <= 1'b0;
        frame(1'b0);
        frame(1'b0);
        idle();
        chk(q[2], 8'h3c);
        chk(q[5], 8'h11);
        chk(q[7], 8'hff);
        chk(q[14], 8'hff);
        chk(q[22], 8'h3c);
        wrr(8'h14, 8'h00);
        q.delete();
        frame(1'b0);
        idle();
        chk(q[2], 8'hc2);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_sec();
        t_line();
        t_tx();
        end_sim();
    end
    initial begin
        #100us;
        failures++;
        end_sim();
    end
endmodule
